// [src/ptms_defines.vh]
/*
 * constants for the power telemetry and register-read service: command
 * codes, lengths, completion codes, field positions and reset values.
 * assumes inclusion by the service module and the checker, by its bare name.
 */
`ifndef PTMS_DEFINES_VH
`define PTMS_DEFINES_VH

// service selectors on the request port
`define PTMS_SVC_TEMP 4'h0
`define PTMS_SVC_THERM 4'h1
`define PTMS_SVC_ILIM 4'h2
`define PTMS_SVC_ENERGY 4'h3
`define PTMS_SVC_CORE_CAP 4'h4
`define PTMS_SVC_PKG_LO 4'h5
`define PTMS_SVC_PKG_HI 4'h6
`define PTMS_SVC_PERF 4'h7
`define PTMS_SVC_SCALE 4'h8
`define PTMS_SVC_RETIRED 4'h9
`define PTMS_SVC_UNITS 4'ha
`define PTMS_SVC_CORES 4'hb

// register read command framing
`define PTMS_CMD_MSR 8'hb1
`define PTMS_WL_MSR 8'h05
`define PTMS_RL_BYTE 8'h02
`define PTMS_RL_WORD 8'h03
`define PTMS_RL_DWORD 8'h05
`define PTMS_RL_QWORD 8'h09
`define PTMS_MAX_PID 8'h0b
`define PTMS_NUM_THREADS 12

// completion codes
`define PTMS_CC_OK 8'h40
`define PTMS_CC_TMO 8'h80
`define PTMS_CC_BUSY 8'h81
`define PTMS_CC_LOWPWR 8'h82
`define PTMS_CC_INVALID 8'h90
`define PTMS_CC_INTERR 8'h91

// limit word fields
`define PTMS_LIM_HI 14
`define PTMS_EN_BIT 15
`define PTMS_CLAMP_BIT 16
`define PTMS_WIN_HI 23
`define PTMS_WIN_LO 17
`define PTMS_RSV_LO 24
`define PTMS_HI_BASE 32
`define PTMS_ILIM_W 13
`define PTMS_ILIM_RST 13'h0258
`define PTMS_CAP_RST 32'h00000000

// unit word fields
`define PTMS_PWR_HI 19
`define PTMS_PWR_LO 16
`define PTMS_EU_HI 11
`define PTMS_EU_LO 8
`define PTMS_TU_HI 3
`define PTMS_TU_LO 0
`define PTMS_PWR_RST 4'h7
`define PTMS_EU_RST 4'h0
`define PTMS_TU_RST 4'h3

// enabled-cores word fields
`define PTMS_CORE_HI 7
`define PTMS_THR_HI 9
`define PTMS_THR_LO 8

`endif

// [src/ptms_service.v]
/*
 * request/answer service: telemetry reads, power limit words and the
 * core register read command with completion code.
 * counters wrap at 32 bits; writes to reserved cap bits are dropped.
 * the units word is fixed at its reset value; no write path reaches it.
 * assumes the link framing layer delivers decoded requests as one-cycle
 * strobes on clk, and that sensors and counters are inputs on clk.
 * the external hot pin is asynchronous and is synchronised here.
 * assumes one register read outstanding; commands in flight are dropped.
 * assumes the core side answers every fetch with one done pulse.
 */
`include "ptms_defines.vh"

module ptms_service (
    // clock and reset
    input wire clk,
    input wire resetn,
    // telemetry request
    input wire req_valid,
    input wire req_write,
    input wire [3:0] req_service,
    input wire [7:0] req_param,
    input wire [31:0] req_wdata,
    output reg rsp_valid,
    output reg [31:0] rsp_data,
    // register read command
    input wire msr_valid,
    input wire [7:0] msr_cmd,
    input wire [7:0] msr_wl,
    input wire [7:0] msr_rl,
    input wire [7:0] msr_pid,
    input wire [15:0] msr_addr,
    output reg msr_rsp_valid,
    output reg [7:0] msr_cc,
    output reg [63:0] msr_data,
    output reg [3:0] msr_nbytes,
    output reg msr_abort,
    // register file fetch, filled by the core side
    output reg msr_fetch,
    output reg [7:0] msr_fetch_pid,
    output reg [15:0] msr_fetch_addr,
    input wire msr_fetch_done,
    input wire msr_fetch_ok,
    input wire [63:0] msr_fetch_data,
    // status from the package
    input wire [8*`PTMS_NUM_THREADS-1:0] core_temp_raw,
    input wire [11:0] thread_present,
    input wire [7:0] core_mask,
    input wire [1:0] thread_mask,
    input wire low_power,
    input wire tcc_active,
    input wire tcc_ramp,
    input wire external_hot_pin,
    input wire below_request,
    input wire time_tick,
    input wire energy_pkg_inc,
    input wire energy_core_inc,
    input wire retired_inc,
    input wire [31:0] perf_ratio,
    // limit and unit outputs
    output wire core_limit_active,
    output wire core_clamp,
    output wire pkg1_limit_active,
    output wire pkg2_limit_active,
    output wire [3:0] power_unit,
    output wire [3:0] time_unit
);

    // one-hot states of the register read sequencer
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_DONE = 3'b100;

    // programmable and fixed words
    reg [31:0] core_plane_power_cap_q;
    reg [63:0] package_dual_power_cap_q;
    reg [`PTMS_ILIM_W-1:0] ilim_q;
    reg [31:0] units_q;

    // wrapping telemetry counters
    reg [31:0] therm_time_q;
    reg [31:0] perf_time_q;
    reg [31:0] energy_pkg_q;
    reg [31:0] energy_core_q;
    reg [31:0] retired_q;

    // hot pin synchroniser
    reg hot_meta_q;
    reg hot_sync_q;

    // register read sequencer state and captured length
    reg [2:0] state_q;
    reg [7:0] rl_q;

    // request decode and read mux
    reg [31:0] rd_d;
    wire svc_rd;
    wire svc_wr;
    wire hot_caused;

    // byte count carried by a read length, zero when illegal
    function [3:0] len_bytes;
        input [7:0] rl;
        begin
            case (rl)
                `PTMS_RL_BYTE: len_bytes = 4'h1;
                `PTMS_RL_WORD: len_bytes = 4'h2;
                `PTMS_RL_DWORD: len_bytes = 4'h4;
                `PTMS_RL_QWORD: len_bytes = 4'h8;
                default: len_bytes = 4'h0;
            endcase
        end
    endfunction

    // mask data to the number of bytes asked for, low byte first
    function [63:0] trim;
        input [63:0] d;
        input [3:0] n;
        begin
            case (n)
                4'h1: trim = {56'h0, d[7:0]};
                4'h2: trim = {48'h0, d[15:0]};
                4'h4: trim = {32'h0, d[31:0]};
                default: trim = d;
            endcase
        end
    endfunction

    // limit word as stored; reserved bits 31:24 always read zero
    function [31:0] cap_word;
        input [31:0] w;
        begin
            cap_word = {8'h0, w[`PTMS_WIN_HI:0]};
        end
    endfunction

    // a processor id names one fixed thread slot; ids past the last
    // slot or naming an absent thread are refused
    function thread_ok;
        input [7:0] pid;
        input [11:0] present;
        begin
            thread_ok = 1'b0;
            if (pid <= `PTMS_MAX_PID)
                thread_ok = present[pid[3:0]];
        end
    endfunction

    // request kind decode
    assign svc_rd = req_valid && !req_write;
    assign svc_wr = req_valid && req_write;

    // the hot pin comes from outside; two flops before use
    always @(posedge clk) begin
        if (!resetn) begin
            hot_meta_q <= 1'b0;
            hot_sync_q <= 1'b0;
        end else begin
            hot_meta_q <= external_hot_pin;
            hot_sync_q <= hot_meta_q;
        end
    end

    // activation driven by the hot pin is not counted
    assign hot_caused = hot_sync_q;

    // limit enables gate the limiters; clamp passes through
    assign core_limit_active = core_plane_power_cap_q[`PTMS_EN_BIT];
    assign core_clamp = core_plane_power_cap_q[`PTMS_CLAMP_BIT];
    assign pkg1_limit_active = package_dual_power_cap_q[`PTMS_EN_BIT];
    assign pkg2_limit_active =
        package_dual_power_cap_q[`PTMS_HI_BASE+`PTMS_EN_BIT];
    // limits and windows are scaled by these units downstream
    assign power_unit = units_q[`PTMS_PWR_HI:`PTMS_PWR_LO];
    assign time_unit = units_q[`PTMS_TU_HI:`PTMS_TU_LO];

    // writable limit words; reserved bits stay zero
    always @(posedge clk) begin
        if (!resetn) begin
            // caps disabled, current limit and units at defaults
            core_plane_power_cap_q <= `PTMS_CAP_RST;
            package_dual_power_cap_q <= {`PTMS_CAP_RST, `PTMS_CAP_RST};
            ilim_q <= `PTMS_ILIM_RST;
            units_q <= 32'h0;
            units_q[`PTMS_PWR_HI:`PTMS_PWR_LO] <= `PTMS_PWR_RST;
            units_q[`PTMS_EU_HI:`PTMS_EU_LO] <= `PTMS_EU_RST;
            units_q[`PTMS_TU_HI:`PTMS_TU_LO] <= `PTMS_TU_RST;
        end else if (svc_wr) begin
            case (req_service)
                `PTMS_SVC_CORE_CAP:
                    core_plane_power_cap_q <=
                        cap_word(req_wdata);
                `PTMS_SVC_PKG_LO:
                    package_dual_power_cap_q[31:0] <=
                        cap_word(req_wdata);
                `PTMS_SVC_PKG_HI:
                    package_dual_power_cap_q[63:32] <=
                        cap_word(req_wdata);
                default: ;
            endcase
        end
    end

    // wrapping accumulators
    always @(posedge clk) begin
        if (!resetn) begin
            therm_time_q <= 32'h0;
            perf_time_q <= 32'h0;
            energy_pkg_q <= 32'h0;
            energy_core_q <= 32'h0;
            retired_q <= 32'h0;
        end else begin
            // ramp time counts too, hot-pin activation does not
            if (time_tick && (tcc_active || tcc_ramp) && !hot_caused)
                therm_time_q <= therm_time_q + 32'h1;
            // throttle time, in time units
            if (time_tick && below_request)
                perf_time_q <= perf_time_q + 32'h1;
            // energy per plane, in energy units
            if (energy_pkg_inc)
                energy_pkg_q <= energy_pkg_q + 32'h1;
            if (energy_core_inc)
                energy_core_q <= energy_core_q + 32'h1;
            // one count per 128 retired instructions
            if (retired_inc)
                retired_q <= retired_q + 32'h1;
        end
    end

    // read mux for telemetry requests
    always @* begin
        rd_d = 32'h0;
        case (req_service)
            // live sample; ids past the last thread read zero
            `PTMS_SVC_TEMP:
                if (req_param < `PTMS_NUM_THREADS)
                    rd_d = {24'h0, core_temp_raw[req_param[3:0]*8 +: 8]};
            `PTMS_SVC_THERM: rd_d = therm_time_q;
            `PTMS_SVC_ILIM: rd_d = {19'h0, ilim_q};
            // parameter zero picks the package, else the core plane
            `PTMS_SVC_ENERGY:
                rd_d = (req_param == 8'h0) ? energy_pkg_q
                                           : energy_core_q;
            `PTMS_SVC_CORE_CAP: rd_d = core_plane_power_cap_q;
            `PTMS_SVC_PKG_LO: rd_d = package_dual_power_cap_q[31:0];
            `PTMS_SVC_PKG_HI: rd_d = package_dual_power_cap_q[63:32];
            `PTMS_SVC_PERF: rd_d = perf_time_q;
            `PTMS_SVC_SCALE: rd_d = perf_ratio;
            `PTMS_SVC_RETIRED: rd_d = retired_q;
            `PTMS_SVC_UNITS: rd_d = units_q;
            `PTMS_SVC_CORES: rd_d = {22'h0, thread_mask, core_mask};
            default: rd_d = 32'h0;
        endcase
    end

    // telemetry answer one cycle after the request
    // writes pulse the answer but leave the read data standing
    always @(posedge clk) begin
        if (!resetn) begin
            rsp_valid <= 1'b0;
            rsp_data <= 32'h0;
        end else begin
            rsp_valid <= req_valid;
            if (svc_rd)
                rsp_data <= rd_d;
        end
    end

    // register read command sequencer
    always @(posedge clk) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            // idle, no answer pending, outputs cleared
            rl_q <= 8'h0;
            msr_rsp_valid <= 1'b0;
            msr_cc <= 8'h0;
            msr_data <= 64'h0;
            msr_nbytes <= 4'h0;
            msr_abort <= 1'b0;
            msr_fetch <= 1'b0;
            msr_fetch_pid <= 8'h0;
            msr_fetch_addr <= 16'h0;
        end else begin
            msr_rsp_valid <= 1'b0;
            msr_fetch <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (msr_valid) begin
                        // keep the length to trim the answer later
                        rl_q <= msr_rl;
                        msr_data <= 64'h0;
                        msr_nbytes <= len_bytes(msr_rl);
                        msr_abort <= 1'b0;
                        if (msr_cmd != `PTMS_CMD_MSR ||
                            msr_wl != `PTMS_WL_MSR ||
                            len_bytes(msr_rl) == 4'h0) begin
                            // bad framing: abort with the invalid code
                            msr_abort <= 1'b1;
                            msr_cc <= `PTMS_CC_INVALID;
                            state_q <= ST_DONE;
                        end else if (!thread_ok(msr_pid,
                                                thread_present)) begin
                            // fixed id-to-thread map, absent thread
                            msr_cc <= `PTMS_CC_INVALID;
                            state_q <= ST_DONE;
                        end else if (low_power) begin
                            msr_cc <= `PTMS_CC_LOWPWR;
                            state_q <= ST_DONE;
                        end else begin
                            // hand the request to the core side
                            msr_fetch <= 1'b1;
                            msr_fetch_pid <= msr_pid;
                            msr_fetch_addr <= msr_addr;
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    // hold until the core side answers
                    if (msr_fetch_done) begin
                        if (msr_fetch_ok) begin
                            msr_cc <= `PTMS_CC_OK;
                            msr_data <= trim(msr_fetch_data,
                                             len_bytes(rl_q));
                        end else begin
                            // register not readable over the link
                            msr_cc <= `PTMS_CC_INVALID;
                        end
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // one-cycle answer; code and data stand after it
                    msr_rsp_valid <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule

// [bench/ptms_asserts.sv]
/*
 * checker for ptms_service: answer timing, field widths, units and
 * register read completion codes.
 * assumes it is bound to ptms_service and sees only its ports.
 */
`include "ptms_defines.vh"

module ptms_asserts (
    // clock and reset
    input wire clk,
    input wire resetn,
    // telemetry side
    input wire req_valid,
    input wire [3:0] req_service,
    input wire rsp_valid,
    input wire [31:0] rsp_data,
    // register read side
    input wire msr_rsp_valid,
    input wire [7:0] msr_cc,
    input wire msr_abort,
    input wire msr_fetch,
    input wire [7:0] msr_fetch_pid,
    input wire msr_fetch_done,
    input wire msr_fetch_ok,
    input wire [11:0] thread_present,
    // unit outputs
    input wire [3:0] power_unit,
    input wire [3:0] time_unit
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // telemetry answer comes exactly one cycle after each request
    a_rsp_next: assert property (req_valid |=> rsp_valid)
        else $error("telemetry answer missing");
    a_rsp_quiet: assert property (!req_valid |=> !rsp_valid)
        else $error("telemetry answer without request");
    // read data field widths and fixed unit outputs
    a_ilim_width: assert property (rsp_valid
        && $past(req_service) == `PTMS_SVC_ILIM |-> rsp_data[31:13] == 0)
        else $error("current limit wider than 13 bits");
    a_cap_rsvd: assert property (rsp_valid
        && $past(req_service) == `PTMS_SVC_CORE_CAP
        |-> rsp_data[31:24] == 0)
        else $error("cap reserved bits set");
    a_units_fixed: assert property (power_unit == 4'h7
        && time_unit == 4'h3)
        else $error("unit fields wrong");
    // register read completion
    a_abort_cc: assert property (msr_rsp_valid && msr_abort
        |-> msr_cc == `PTMS_CC_INVALID)
        else $error("abort without invalid code");
    a_fetch_resp: assert property (msr_fetch_done |-> ##2 msr_rsp_valid)
        else $error("no answer two cycles after fetch");
    a_fetch_cc: assert property (msr_rsp_valid
        && $past(msr_fetch_done, 2) |-> msr_cc == ($past(msr_fetch_ok, 2)
        ? `PTMS_CC_OK : `PTMS_CC_INVALID))
        else $error("fetch completion code wrong");
    a_fetch_pid: assert property (msr_fetch
        |-> msr_fetch_pid <= `PTMS_MAX_PID
        && thread_present[msr_fetch_pid[3:0]])
        else $error("fetch for unavailable thread");
    // main scenarios reached
    c_fetch: cover property (msr_fetch_done ##2 msr_rsp_valid);
    c_abort: cover property (msr_rsp_valid && msr_abort);
    c_rsp: cover property (rsp_valid);
endmodule

bind ptms_service ptms_asserts i_chk (.clk, .resetn, .req_valid,
    .req_service, .rsp_valid, .rsp_data, .msr_rsp_valid, .msr_cc,
    .msr_abort, .msr_fetch, .msr_fetch_pid, .msr_fetch_done,
    .msr_fetch_ok, .thread_present, .power_unit, .time_unit);

// [bench/ptms_fetch_model.sv]
/*
 * core side model: answers each register fetch after one or six cycles.
 * assumes one fetch outstanding; address 16'hffff is not implemented.
 */
module ptms_fetch_model (
    // clock and reset
    input wire clk,
    input wire resetn,
    // fetch request
    input wire msr_fetch,
    input wire [7:0] msr_fetch_pid,
    input wire [15:0] msr_fetch_addr,
    input wire slow,
    // answer
    output logic msr_fetch_done,
    output logic msr_fetch_ok,
    output logic [63:0] msr_fetch_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_q;
    logic [63:0] pat_q;

    // delay the answer; data toggles whenever it is not valid
    always @(posedge clk) begin
        msr_fetch_done <= 0;
        msr_fetch_data <= ~msr_fetch_data;
        if (!resetn) begin
            wait_q <= 0;
            msr_fetch_ok <= 0;
            msr_fetch_data <= 0;
        end else if (msr_fetch) begin
            wait_q <= slow ? 8'h06 : 8'h01;
            msr_fetch_ok <= msr_fetch_addr != 16'hffff;
            pat_q <= {msr_fetch_addr, 8'ha5, msr_fetch_pid,
                ~msr_fetch_addr, msr_fetch_addr};
        end else if (wait_q == 1) begin
            wait_q <= 0;
            msr_fetch_done <= 1;
            msr_fetch_data <= pat_q;
        end else if (wait_q != 0) begin
            wait_q <= wait_q - 1;
        end
    end
endmodule

// [bench/tb_top.sv]
/*
 * testbench for ptms_service: defaults, caps, counters, temperature
 * and the register read command against the fetch model.
 * assumes ptms_defines.vh on the include path.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, resetn = 0, slow = 0;
    logic req_valid = 0, req_write = 0, msr_valid = 0;
    logic [3:0] req_service = 0;
    logic [7:0] req_param = 0, msr_cmd = 0, msr_wl = 8'h05, msr_rl = 0;
    logic [7:0] msr_pid = 0, core_mask = 8'h3c;
    logic [31:0] req_wdata = 0, perf_ratio = 32'h1234, rdat;
    logic [15:0] msr_addr = 0;
    logic [95:0] core_temp_raw = 0;
    logic [11:0] thread_present = 12'hff7;
    logic [1:0] thread_mask = 2'h1;
    logic low_power = 0, tcc_active = 0, tcc_ramp = 0;
    logic external_hot_pin = 0, below_request = 0, time_tick = 0;
    logic energy_pkg_inc = 0, energy_core_inc = 0, retired_inc = 0;
    logic rsp_valid, msr_rsp_valid, msr_abort, msr_fetch;
    logic msr_fetch_done, msr_fetch_ok;
    logic core_limit_active, core_clamp, pkg1_limit_active;
    logic pkg2_limit_active;
    logic [31:0] rsp_data;
    logic [7:0] msr_cc, msr_fetch_pid;
    logic [63:0] msr_data, msr_fetch_data;
    logic [3:0] msr_nbytes, power_unit, time_unit;
    logic [15:0] msr_fetch_addr;
    int n_fail = 0, cmp_count = 0;

    // design and core side model
    ptms_service i_dut (.clk, .resetn, .req_valid, .req_write,
        .req_service, .req_param, .req_wdata, .rsp_valid, .rsp_data,
        .msr_valid, .msr_cmd, .msr_wl, .msr_rl, .msr_pid, .msr_addr,
        .msr_rsp_valid, .msr_cc, .msr_data, .msr_nbytes, .msr_abort,
        .msr_fetch, .msr_fetch_pid, .msr_fetch_addr, .msr_fetch_done,
        .msr_fetch_ok, .msr_fetch_data, .core_temp_raw, .thread_present,
        .core_mask, .thread_mask, .low_power, .tcc_active, .tcc_ramp,
        .external_hot_pin, .below_request, .time_tick, .energy_pkg_inc,
        .energy_core_inc, .retired_inc, .perf_ratio, .core_limit_active,
        .core_clamp, .pkg1_limit_active, .pkg2_limit_active, .power_unit,
        .time_unit);
    ptms_fetch_model i_fetch (.clk, .resetn, .msr_fetch, .msr_fetch_pid,
        .msr_fetch_addr, .slow, .msr_fetch_done, .msr_fetch_ok,
        .msr_fetch_data);

    // 40 MHz clock
    always #12.5ns clk = ~clk;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d failures %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one telemetry request; v is write data and parameter
    task automatic xfer(input logic w, input logic [3:0] s,
                        input logic [31:0] v);
        @(negedge clk);
        req_valid = 1;
        req_write = w;
        req_service = s;
        req_param = v[7:0];
        req_wdata = v;
        @(negedge clk);
        req_valid = 0;
        chk(rsp_valid, 1);
        rdat = rsp_data;
    endtask

    // one register read command, waits for its answer
    task automatic model_specific_register(input logic [7:0] c, r, p, input logic [15:0] a);
        int i;
        @(negedge clk);
        msr_valid = 1;
        msr_cmd = c;
        msr_rl = r;
        msr_pid = p;
        msr_addr = a;
        @(negedge clk);
        msr_valid = 0;
        i = 0;
        while (msr_rsp_valid !== 1 && i < 20) begin
            @(negedge clk);
            i++;
        end
        chk(i < 20, 1);
    endtask

    // several counter pulses, core energy optional
    task automatic pulse(input int n, input logic c);
        repeat (n) begin
            @(negedge clk);
            {time_tick, energy_pkg_inc, retired_inc} = 3'h7;
            energy_core_inc = c;
            @(negedge clk);
            {time_tick, energy_pkg_inc, retired_inc, energy_core_inc} = 0;
        end
    endtask

    task automatic t_defaults;
        xfer(0, 4'h2, 0); chk(rdat, 32'h258);
        xfer(1, 4'h2, 0); xfer(0, 4'h2, 0); chk(rdat, 32'h258);
        xfer(0, 4'ha, 0); chk(rdat, 32'h00070003);
        chk({power_unit, time_unit}, 8'h73);
        xfer(0, 4'h8, 0); chk(rdat, 32'h1234);
        xfer(0, 4'hb, 0); chk(rdat, 32'h13c);
    endtask

    task automatic t_caps;
        xfer(1, 4'h4, 32'hffffffff); xfer(0, 4'h4, 0);
        chk(rdat, 32'h00ffffff);
        chk({core_clamp, core_limit_active}, 2'h3);
        xfer(1, 4'h4, 32'h00008000);
        chk({core_clamp, core_limit_active}, 2'h1);
        xfer(1, 4'h5, 32'h00008000); xfer(1, 4'h6, 32'h0);
        chk({pkg2_limit_active, pkg1_limit_active}, 2'h1);
        xfer(1, 4'h6, 32'hffffffff); xfer(0, 4'h6, 0);
        chk(rdat, 32'h00ffffff);
        xfer(0, 4'h5, 0); chk(rdat, 32'h00008000);
        chk(pkg2_limit_active, 1);
    endtask

    task automatic t_counts;
        tcc_active = 1;
        below_request = 1;
        pulse(5, 1);
        external_hot_pin = 1;
        repeat (3) @(negedge clk);
        pulse(2, 0);
        {external_hot_pin, tcc_active, tcc_ramp} = 3'h1;
        repeat (3) @(negedge clk);
        pulse(2, 0);
        xfer(0, 4'h1, 0); chk(rdat, 7);
        xfer(0, 4'h7, 0); chk(rdat, 9);
        xfer(0, 4'h9, 0); chk(rdat, 9);
        xfer(0, 4'h3, 0); chk(rdat, 9);
        xfer(0, 4'h3, 1); chk(rdat, 5);
    endtask

    task automatic t_temp;
        for (int k = 0; k < 12; k++)
            core_temp_raw[8*k +: 8] = 8'h20 + 8'(k);
        xfer(0, 4'h0, 11); chk(rdat[7:0], 8'h2b);
        core_temp_raw[95:88] = 8'h55;
        xfer(0, 4'h0, 11); chk(rdat[7:0], 8'h55);
    endtask

    task automatic t_msr;
        logic [7:0] rls [4];
        logic [63:0] pat;
        rls = '{8'h02, 8'h03, 8'h05, 8'h09};
        pat = {16'h0401, 8'ha5, 8'h01, 16'hfbfe, 16'h0401};
        for (int k = 0; k < 4; k++) begin
            slow = k[0];
            model_specific_register(8'hb1, rls[k], 8'h01, 16'h0401);
            chk(msr_cc, 8'h40);
            chk(msr_nbytes, 64'(1) << k);
            chk(msr_data, pat & ((64'h1 << (8 << k)) - 1));
        end
        model_specific_register(8'hb1, 8'h09, 8'd11, 16'h0402); chk(msr_cc, 8'h40);
        model_specific_register(8'hb1, 8'h09, 8'd12, 16'h0402); chk(msr_cc, 8'h90);
        model_specific_register(8'hb1, 8'h09, 8'd3, 16'h0402); chk(msr_cc, 8'h90);
        model_specific_register(8'hb1, 8'h09, 8'd2, 16'hffff); chk(msr_cc, 8'h90);
        model_specific_register(8'hb2, 8'h09, 8'd2, 16'h0402);
        chk({msr_abort, msr_cc}, 9'h190);
        low_power = 1;
        model_specific_register(8'hb1, 8'h09, 8'd2, 16'h0402); chk(msr_cc, 8'h82);
        low_power = 0;
    endtask

    // enumerate every thread id the way a host would
    task automatic t_enum;
        for (int k = 0; k <= 11; k++) begin
            model_specific_register(8'hb1, 8'h02, 8'(k), 16'h0401);
            chk(msr_cc, thread_present[k] ? 8'h40 : 8'h90);
        end
    endtask

    // reset in mid-run clears counters and caps
    task automatic t_rerun;
        @(negedge clk);
        resetn = 0;
        repeat (3) @(negedge clk);
        resetn = 1;
        xfer(0, 4'h1, 0); chk(rdat, 0);
        xfer(0, 4'h5, 0); chk(rdat, 0);
        xfer(0, 4'h4, 0); chk(rdat, 0);
    endtask

    // main sequence
    initial begin
        repeat (3) @(negedge clk);
        resetn = 1;
        t_defaults;
        t_caps;
        t_counts;
        t_temp;
        t_msr;
        t_enum;
        t_rerun;
        print_verdict;
    end

    // watchdog against a hang
    initial begin
        #(5000 * 25ns);
        n_fail++;
        print_verdict;
    end
endmodule
